// File: hw/agu_pkg.sv
// Package with types and constants of the modulo and bit-reversed address generator
package agu_pkg;

  // ==========================================================================
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] OFS_ADDR_MODE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_X_CIRC_START_ADDR = 8'h04;
  localparam logic [7:0] OFS_X_CIRC_END_ADDR = 8'h08;
  localparam logic [7:0] OFS_Y_CIRC_START_ADDR = 8'h0C;
  localparam logic [7:0] OFS_Y_CIRC_END_ADDR = 8'h10;
  localparam logic [7:0] OFS_BIT_REVERSE_CONTROL = 8'h14;
  localparam logic [7:0] OFS_AGU_STATUS = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int X_CIRC_SEL_LSB = 0;
  localparam int Y_CIRC_SEL_LSB = 4;
  localparam int BITREV_SEL_LSB = 8;
  localparam int Y_CIRC_ENABLE_BIT = 14;
  localparam int X_CIRC_ENABLE_BIT = 15;
  localparam int BITREV_ENABLE_BIT = 15;
  localparam int STAT_CIRC_BIT = 16;
  localparam int STAT_BITREV_BIT = 17;
  localparam int STAT_ERR_BIT = 18;

  // ==========================================================================
  // Reset values and fixed codes
  localparam logic [15:0] RST_ADDR_MODE_CONTROL = 16'h0FFF;
  localparam logic [15:0] RST_CIRC_ADDR = 16'h0000;
  localparam logic [15:0] RST_BIT_REVERSE_CONTROL = 16'h0000;
  localparam logic [3:0] PTR_SEL_NONE = 4'hF;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] STEP_PF2 = 16'h0002;
  localparam logic [15:0] STEP_PF4 = 16'h0004;
  localparam logic [15:0] STEP_PF6 = 16'h0006;

  // ==========================================================================
  // Addressing modes presented by the instruction decoder
  typedef enum logic [3:0] {
    AM_REG_DIRECT = 4'h0,
    AM_IND = 4'h1,
    AM_POST_INC = 4'h2,
    AM_POST_DEC = 4'h3,
    AM_PRE_INC = 4'h4,
    AM_PRE_DEC = 4'h5,
    AM_REG_OFS = 4'h6,
    AM_LIT_OFS = 4'h7,
    AM_LIT8 = 4'h8,
    AM_LIT16 = 4'h9,
    AM_BRANCH = 4'hA,
    AM_INTERRUPT_DISABLE_INSTR = 4'hB,
    AM_PF_POST2 = 4'hC,
    AM_PF_POST4 = 4'hD,
    AM_PF_POST6 = 4'hE
  } agu_mode_t;

  // Bus slave states, Gray coded
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_t;

  // Address request from the decoder
  typedef struct packed {
    logic valid;
    agu_mode_t mode;
    logic [3:0] ptr_idx;
    logic [15:0] ptr_val;
    logic [15:0] ofs_val;
    logic [15:0] lit;
    logic y_space;
    logic is_write;
    logic is_byte;
    logic prefetch;
    logic move_dst;
  } agu_req_t;

  // Address answer to the data memory and register file
  typedef struct packed {
    logic valid;
    logic [15:0] ea;
    logic y_space;
    logic wb_en;
    logic [3:0] wb_idx;
    logic [15:0] wb_val;
    logic [15:0] lit;
    logic circ_hit;
    logic bitrev_hit;
    logic mode_err;
  } agu_rsp_t;

  // Complete state of the generator
  typedef struct packed {
    bus_state_t bus;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] addr_mode_control;
    logic [15:0] x_circ_start_addr;
    logic [15:0] x_circ_end_addr;
    logic [15:0] y_circ_start_addr;
    logic [15:0] y_circ_end_addr;
    logic [15:0] bit_reverse_control;
    logic [15:0] shared_ofs;
    agu_rsp_t rsp;
  } agu_state_t;

endpackage

// File: hw/modulo_bitrev_address_gen.sv
// Effective-address generator with circular and bit-reversed addressing
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module modulo_bitrev_address_gen
  import agu_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Decoder request and memory answer
  input wire agu_req_t req_i,
  output agu_rsp_t rsp_o
);

  // ==========================================================================
  // Helper functions

  // Mirror a 16-bit word
  function automatic logic [15:0] bitrev16(input logic [15:0] a);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = a[15 - i];
    end
    return r;
  endfunction

  // Add with carry running from the top bit downward
  function automatic logic [15:0] rev_add(input logic [15:0] a, input logic [15:0] m);
    logic [15:0] s;
    s = bitrev16(a) + bitrev16(m);
    return bitrev16(s);
  endfunction

  // Wrap an address into the circular window
  function automatic logic [15:0] circ_fix(input logic [15:0] a, input logic [15:0] s,
                                           input logic [15:0] e, input logic up);
    logic [16:0] len;
    logic pow2;
    logic [16:0] r;
    len = {1'b0, e} - {1'b0, s} + 17'h00001;
    pow2 = ((len & (len - 17'h00001)) == 17'h00000);
    r = {1'b0, a};
    if ((up || pow2) && (a > e))
    begin
      r = {1'b0, a} - len;
    end
    else if ((!up || pow2) && (a < s))
    begin
      r = {1'b0, a} + len;
    end
    return r[15:0];
  endfunction

  // Apply a byte-lane write to a 16-bit register
  function automatic logic [15:0] lane_wr(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
    begin
      r[7:0] = d[7:0];
    end
    if (sel[1])
    begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // ==========================================================================
  // State

  agu_state_t st;
  agu_state_t next_st;

  logic [3:0] x_sel;
  logic [3:0] y_sel;
  logic [3:0] b_sel;
  logic x_circ_on;
  logic y_circ_on;
  logic brev_on;
  logic [15:0] step;
  logic [15:0] ofs;
  logic [15:0] mod_addr;
  logic [15:0] sum_addr;
  logic [15:0] calc;
  logic calc_up;
  logic use_calc;
  logic is_y;
  logic pf_bad;
  logic circ_use;
  logic brev_use;
  logic [15:0] brev_addr;
  logic [15:0] fixed_addr;
  logic [31:0] rd_word;

  // Control field decode
  assign x_sel = st.addr_mode_control[X_CIRC_SEL_LSB +: 4];
  assign y_sel = st.addr_mode_control[Y_CIRC_SEL_LSB +: 4];
  assign b_sel = st.addr_mode_control[BITREV_SEL_LSB +: 4];
  assign x_circ_on = (x_sel != PTR_SEL_NONE) &&
                     st.addr_mode_control[X_CIRC_ENABLE_BIT];
  assign y_circ_on = (y_sel != PTR_SEL_NONE) &&
                     st.addr_mode_control[Y_CIRC_ENABLE_BIT];
  assign brev_on = (b_sel != PTR_SEL_NONE) && st.bit_reverse_control[BITREV_ENABLE_BIT];

  // ==========================================================================
  // Address arithmetic

  // Step size and shared offset selection
  always_comb
  begin
    step = req_i.is_byte ? STEP_BYTE : STEP_WORD;
    case (req_i.mode)
      AM_PF_POST2: step = STEP_PF2;
      AM_PF_POST4: step = STEP_PF4;
      AM_PF_POST6: step = STEP_PF6;
      default: step = req_i.is_byte ? STEP_BYTE : STEP_WORD;
    endcase
    // Destination of a move reuses the offset held from its source
    ofs = req_i.move_dst ? st.shared_ofs : req_i.ofs_val;
  end

  // Modified and offset addresses
  always_comb
  begin
    mod_addr = req_i.ptr_val + step;
    calc_up = 1'b1;
    use_calc = 1'b0;
    sum_addr = req_i.ptr_val + ofs;
    case (req_i.mode)
      AM_POST_DEC, AM_PRE_DEC:
      begin
        mod_addr = req_i.ptr_val - step;
        calc_up = 1'b0;
        use_calc = 1'b1;
      end
      AM_POST_INC, AM_PRE_INC, AM_PF_POST2, AM_PF_POST4, AM_PF_POST6:
      begin
        use_calc = 1'b1;
      end
      AM_REG_OFS:
      begin
        calc_up = !ofs[15];
        use_calc = 1'b1;
      end
      AM_LIT_OFS:
      begin
        sum_addr = req_i.ptr_val + req_i.lit;
        calc_up = !req_i.lit[15];
        use_calc = 1'b1;
      end
      default:
      begin
        use_calc = 1'b0;
      end
    endcase
    calc = (req_i.mode == AM_REG_OFS || req_i.mode == AM_LIT_OFS) ? sum_addr : mod_addr;
  end

  // Space steering, circular and bit-reversed correction
  always_comb
  begin
    // Prefetch pointers are steered by their index alone
    is_y = req_i.prefetch ? req_i.ptr_idx[1] : req_i.y_space;
    pf_bad = 1'b0;
    if (req_i.prefetch)
    begin
      if (req_i.ptr_idx[3:2] != 2'b10)
      begin
        pf_bad = 1'b1;
      end
      case (req_i.mode)
        AM_IND, AM_PF_POST2, AM_PF_POST4, AM_PF_POST6: pf_bad = pf_bad;
        AM_REG_OFS: pf_bad = pf_bad || !req_i.ptr_idx[0];
        default: pf_bad = 1'b1;
      endcase
    end
    else if (req_i.mode == AM_PF_POST2 || req_i.mode == AM_PF_POST4 ||
             req_i.mode == AM_PF_POST6)
    begin
      pf_bad = 1'b1;
    end
    circ_use = use_calc && (is_y ? (y_circ_on && req_i.ptr_idx == y_sel)
                                 : (x_circ_on && req_i.ptr_idx == x_sel));
    brev_use = brev_on && !is_y && req_i.is_write && !req_i.is_byte &&
               req_i.ptr_idx == b_sel &&
               (req_i.mode == AM_POST_INC || req_i.mode == AM_PRE_INC);
    // Pivot scaled to bytes, modifier added in mirrored order
    brev_addr = rev_add(req_i.ptr_val,
                        {st.bit_reverse_control[14:0], 1'b0}) & 16'hFFFE;
    fixed_addr = calc;
    if (circ_use)
    begin
      if (is_y)
      begin
        fixed_addr = circ_fix(calc, st.y_circ_start_addr, st.y_circ_end_addr, calc_up)
                     & 16'hFFFE;
      end
      else
      begin
        fixed_addr = circ_fix(calc, st.x_circ_start_addr, st.x_circ_end_addr, calc_up);
      end
    end
    if (brev_use)
    begin
      fixed_addr = brev_addr;
    end
  end

  // Read word seen by software: control registers and status
  always_comb
  begin
    rd_word = 32'h00000000;
    case (wb_adr_i)
      OFS_ADDR_MODE_CONTROL: rd_word[15:0] = st.addr_mode_control;
      OFS_X_CIRC_START_ADDR: rd_word[15:0] = st.x_circ_start_addr;
      OFS_X_CIRC_END_ADDR: rd_word[15:0] = st.x_circ_end_addr;
      OFS_Y_CIRC_START_ADDR: rd_word[15:0] = st.y_circ_start_addr;
      OFS_Y_CIRC_END_ADDR: rd_word[15:0] = st.y_circ_end_addr;
      OFS_BIT_REVERSE_CONTROL: rd_word[15:0] = st.bit_reverse_control;
      OFS_AGU_STATUS:
      begin
        rd_word[15:0] = st.rsp.ea;
        rd_word[STAT_CIRC_BIT] = st.rsp.circ_hit;
        rd_word[STAT_BITREV_BIT] = st.rsp.bitrev_hit;
        rd_word[STAT_ERR_BIT] = st.rsp.mode_err;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // Next state

  always_comb
  begin
    next_st = st;
    // Wishbone slave: answer one cycle after the request, then drop
    next_st.ack = 1'b0;
    case (st.bus)
      BUS_IDLE:
      begin
        if (wb_cyc_i && wb_stb_i)
        begin
          next_st.bus = BUS_ACK;
          next_st.ack = 1'b1;
          next_st.rdata = wb_we_i ? 32'h00000000 : rd_word;
          if (wb_we_i)
          begin
            case (wb_adr_i)
              OFS_ADDR_MODE_CONTROL:
                next_st.addr_mode_control = lane_wr(st.addr_mode_control, wb_dat_i, wb_sel_i);
              OFS_X_CIRC_START_ADDR:
                next_st.x_circ_start_addr = lane_wr(st.x_circ_start_addr, wb_dat_i, wb_sel_i);
              OFS_X_CIRC_END_ADDR:
                next_st.x_circ_end_addr = lane_wr(st.x_circ_end_addr, wb_dat_i, wb_sel_i);
              OFS_Y_CIRC_START_ADDR:
                next_st.y_circ_start_addr = lane_wr(st.y_circ_start_addr, wb_dat_i, wb_sel_i);
              OFS_Y_CIRC_END_ADDR:
                next_st.y_circ_end_addr = lane_wr(st.y_circ_end_addr, wb_dat_i, wb_sel_i);
              OFS_BIT_REVERSE_CONTROL:
                next_st.bit_reverse_control =
                  lane_wr(st.bit_reverse_control, wb_dat_i, wb_sel_i);
              default: next_st.rdata = 32'h00000000;
            endcase
          end
        end
      end
      BUS_ACK: next_st.bus = BUS_IDLE;
      default: next_st.bus = BUS_IDLE;
    endcase

    // Address answer
    next_st.rsp.valid = req_i.valid;
    if (req_i.valid)
    begin
      if (!req_i.move_dst)
      begin
        next_st.shared_ofs = req_i.ofs_val;
      end
      next_st.rsp.y_space = is_y;
      next_st.rsp.wb_idx = req_i.ptr_idx;
      next_st.rsp.wb_en = 1'b0;
      next_st.rsp.wb_val = req_i.ptr_val;
      next_st.rsp.lit = 16'h0000;
      next_st.rsp.ea = req_i.ptr_val;
      next_st.rsp.circ_hit = circ_use && !brev_use;
      next_st.rsp.bitrev_hit = brev_use;
      next_st.rsp.mode_err = pf_bad;
      case (req_i.mode)
        AM_POST_INC, AM_POST_DEC, AM_PF_POST2, AM_PF_POST4, AM_PF_POST6:
        begin
          next_st.rsp.wb_en = !pf_bad;
          // Y circular accesses are word accesses, so the used address stays even
          next_st.rsp.ea = (circ_use && is_y) ? (req_i.ptr_val & 16'hFFFE)
                                              : req_i.ptr_val;
          next_st.rsp.wb_val = fixed_addr;
        end
        AM_PRE_INC, AM_PRE_DEC:
        begin
          next_st.rsp.ea = fixed_addr;
          next_st.rsp.wb_en = !pf_bad;
          next_st.rsp.wb_val = fixed_addr;
        end
        AM_REG_OFS, AM_LIT_OFS: next_st.rsp.ea = fixed_addr;
        AM_LIT8: next_st.rsp.lit = {8'h00, req_i.lit[7:0]};
        AM_LIT16: next_st.rsp.lit = req_i.lit;
        AM_BRANCH: next_st.rsp.lit = req_i.lit;
        AM_INTERRUPT_DISABLE_INSTR: next_st.rsp.lit = {2'b00, req_i.lit[13:0]};
        AM_REG_DIRECT: next_st.rsp.ea = 16'h0000;
        default: next_st.rsp.ea = req_i.ptr_val;
      endcase
    end
    else
    begin
      next_st.rsp.wb_en = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.bus <= BUS_IDLE;
      st.addr_mode_control <= RST_ADDR_MODE_CONTROL;
      st.x_circ_start_addr <= RST_CIRC_ADDR;
      st.x_circ_end_addr <= RST_CIRC_ADDR;
      st.y_circ_start_addr <= RST_CIRC_ADDR;
      st.y_circ_end_addr <= RST_CIRC_ADDR;
      st.bit_reverse_control <= RST_BIT_REVERSE_CONTROL;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign rsp_o = st.rsp;

  // ==========================================================================
  // Assertions

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_LATENCY: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  AST_BRANCH_LIT: assert property (req_i.valid && req_i.mode == AM_BRANCH |=>
    rsp_o.lit == $past(req_i.lit))
    else $error("branch literal not passed whole");
  AST_INTERRUPT_DISABLE_INSTR_LIT: assert property (req_i.valid && req_i.mode == AM_INTERRUPT_DISABLE_INSTR |=>
    rsp_o.lit[15:14] == 2'b00 && rsp_o.lit[13:0] == $past(req_i.lit[13:0]))
    else $error("interrupt-disable literal wrong");
  AST_PF_STEER: assert property (req_i.valid && req_i.prefetch &&
    req_i.ptr_idx[3:2] == 2'b10 |=> rsp_o.y_space == $past(req_i.ptr_idx[1]))
    else $error("prefetch pointer steered to wrong space");
  AST_PF_INDEX: assert property (req_i.valid && req_i.prefetch &&
    req_i.mode == AM_REG_OFS && !req_i.ptr_idx[0] |=> rsp_o.mode_err && !rsp_o.wb_en)
    else $error("indexed prefetch allowed on even pointer");
  AST_PF_MODE: assert property (req_i.valid && req_i.prefetch &&
    !(req_i.mode inside {AM_IND, AM_REG_OFS, AM_PF_POST2, AM_PF_POST4, AM_PF_POST6}) |=>
    rsp_o.mode_err && !rsp_o.wb_en)
    else $error("illegal prefetch mode accepted");
  AST_Y_LSB: assert property (rsp_o.valid && rsp_o.circ_hit && rsp_o.y_space |->
    !rsp_o.ea[0] && (!rsp_o.wb_en || !rsp_o.wb_val[0]))
    else $error("Y circular address has LSb set");
  AST_BREV_WB: assert property (rsp_o.valid && rsp_o.bitrev_hit |->
    rsp_o.wb_en && !rsp_o.wb_val[0] && !rsp_o.circ_hit && !rsp_o.y_space)
    else $error("bit-reversed update malformed");
  AST_OFS_NO_WB: assert property (req_i.valid &&
    (req_i.mode == AM_REG_OFS || req_i.mode == AM_LIT_OFS) |=> !rsp_o.wb_en)
    else $error("offset mode wrote pointer back");
  AST_CIRC_OFF: assert property (req_i.valid && x_sel == PTR_SEL_NONE &&
    y_sel == PTR_SEL_NONE |=> !rsp_o.circ_hit)
    else $error("circular correction while disabled");
  AST_BYTE_NO_BREV: assert property (req_i.valid && req_i.is_byte |=>
    !rsp_o.bitrev_hit)
    else $error("bit reversal on byte access");

  COV_CIRC: cover property (rsp_o.valid && rsp_o.circ_hit && rsp_o.wb_en);
  COV_BREV: cover property (rsp_o.valid && rsp_o.bitrev_hit);
  COV_WRITE: cover property (wb_cyc_i && wb_we_i && wb_ack_o);
  COV_PF: cover property (req_i.valid && req_i.prefetch ##1 rsp_o.y_space);

endmodule

`default_nettype wire

// File: verification/agu_decoder_model.sv
// Model of the instruction decoder that feeds the address generator
`timescale 1ns/1ps
`default_nettype none
module agu_decoder_model
  import agu_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Request out, answer in
  output var agu_req_t req_o,
  input wire agu_rsp_t rsp_i
);
  // ==========================================================================
  // Request driver
  // Nothing is requested before the first call
  initial req_o = '0;
  // One request for one edge; released fields show the inverse of the last value
  // Callers keep prefetch pointers in their space except W7 in the prefetch test, and avoid W14/W15
  // Bit-reversed buffers start aligned; no read follows a control rewrite
  task automatic send(input agu_req_t r, output agu_rsp_t a);
    agu_req_t idle;
    idle = ~r;
    idle.valid = 1'b0;
    @(posedge clk_i);
    req_o <= r;
    @(posedge clk_i);
    req_o <= idle;
    @(posedge clk_i);
    a = rsp_i;
  endtask
endmodule
`default_nettype wire

// File: verification/modulo_bitrev_address_gen_tb.sv
// Self-checking testbench of the modulo and bit-reversed address generator
`timescale 1ns/1ps
`default_nettype none
module modulo_bitrev_address_gen_tb
  import agu_pkg::*;
;
  // ==========================================================================
  // Signals and instances
  localparam logic [4:0] F_Y = 5'h10;
  localparam logic [4:0] F_W = 5'h08;
  localparam logic [4:0] F_B = 5'h04;
  localparam logic [4:0] F_P = 5'h02;
  localparam logic [4:0] F_D = 5'h01;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  agu_req_t req;
  agu_rsp_t rsp_o;
  agu_rsp_t rsp;
  logic [31:0] q;
  int num_errors = 0;
  int checks = 0;
  agu_mode_t pf_mode [8] = '{AM_PF_POST2, AM_PF_POST4, AM_PF_POST6, AM_IND, AM_REG_OFS,
    AM_REG_OFS, AM_PF_POST2, AM_POST_INC};
  logic [3:0] pf_idx [8] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'h9, 4'h8, 4'h7, 4'h9};
  agu_mode_t lit_mode [4] = '{AM_LIT8, AM_LIT16, AM_BRANCH, AM_INTERRUPT_DISABLE_INSTR};
  logic [15:0] lit_exp [4] = '{16'h00AB, 16'hC5AB, 16'hC5AB, 16'h05AB};
  logic [15:0] reg_exp [8] = '{16'h0FFF, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};

  // Clock of 100 MHz
  always #5 clk_i = ~clk_i;

  modulo_bitrev_address_gen dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req),
    .rsp_o(rsp_o));
  agu_decoder_model dec (.clk_i(clk_i), .req_o(req), .rsp_i(rsp_o));

  // ==========================================================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
      num_errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rq(input agu_mode_t m, input logic [3:0] i, input logic [15:0] p,
    input logic [15:0] o, input logic [4:0] f);
    agu_req_t r;
    r = '{valid: 1'b1, mode: m, ptr_idx: i, ptr_val: p, ofs_val: o, lit: o,
      y_space: f[4], is_write: f[3], is_byte: f[2], prefetch: f[1], move_dst: f[0]};
    dec.send(r, rsp);
  endtask

  task automatic cr(input logic [15:0] ea, input logic en, input logic [15:0] val);
    check("valid", rsp.valid, 1'b1);
    check("ea", rsp.ea, ea);
    check("wb_en", rsp.wb_en, en);
    if (en)
      check("wb_val", rsp.wb_val, val);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    for (int k = 0; k < 8; k++)
    begin
      wb(1'b0, 8'(4 * k), 16'h0);
      check("reg", q, {16'h0, reg_exp[k]});
    end
    wb(1'b1, OFS_Y_CIRC_END_ADDR, 16'hA55A);
    wb(1'b0, OFS_Y_CIRC_END_ADDR, 16'h0);
    check("y_end", q, 32'h0000A55A);
  endtask

  task automatic t_xcirc;
    wb(1'b1, OFS_X_CIRC_START_ADDR, 16'h1000);
    wb(1'b1, OFS_X_CIRC_END_ADDR, 16'h101F);
    wb(1'b1, OFS_ADDR_MODE_CONTROL, 16'h0FF2);
    rq(AM_POST_INC, 4'h2, 16'h101E, 16'h0, F_W);
    cr(16'h101E, 1'b1, 16'h1020);
    wb(1'b1, OFS_ADDR_MODE_CONTROL, 16'h8FF2);
    rq(AM_POST_INC, 4'h2, 16'h101E, 16'h0, F_W);
    cr(16'h101E, 1'b1, 16'h1000);
    check("circ_hit", rsp.circ_hit, 1'b1);
    check("wb_idx", rsp.wb_idx, 4'h2);
    rq(AM_POST_DEC, 4'h2, 16'h1000, 16'h0, 5'h0);
    cr(16'h1000, 1'b1, 16'h101E);
    rq(AM_REG_OFS, 4'h2, 16'h101E, 16'h0004, 5'h0);
    cr(16'h1002, 1'b0, 16'h0);
    rq(AM_POST_INC, 4'h5, 16'h101E, 16'h0, 5'h0);
    cr(16'h101E, 1'b1, 16'h1020);
  endtask

  task automatic t_ycirc;
    wb(1'b1, OFS_Y_CIRC_START_ADDR, 16'h2000);
    wb(1'b1, OFS_Y_CIRC_END_ADDR, 16'h2007);
    wb(1'b1, OFS_ADDR_MODE_CONTROL, 16'h4F3F);
    rq(AM_PRE_INC, 4'h3, 16'h2006, 16'h0, F_Y);
    cr(16'h2000, 1'b1, 16'h2000);
    rq(AM_REG_OFS, 4'h3, 16'h2000, 16'h0003, F_Y);
    cr(16'h2002, 1'b0, 16'h0);
    rq(AM_POST_INC, 4'h3, 16'h2003, 16'h0, F_Y);
    cr(16'h2002, 1'b1, 16'h2004);
    check("y_circ_hit", rsp.circ_hit, 1'b1);
    rq(AM_PRE_INC, 4'h3, 16'h2006, 16'h0, 5'h0);
    cr(16'h2008, 1'b1, 16'h2008);
  endtask

  task automatic t_bitrev;
    wb(1'b1, OFS_X_CIRC_START_ADDR, 16'h0800);
    wb(1'b1, OFS_X_CIRC_END_ADDR, 16'h080F);
    wb(1'b1, OFS_ADDR_MODE_CONTROL, 16'h84F4);
    wb(1'b1, OFS_BIT_REVERSE_CONTROL, 16'h8008);
    rq(AM_POST_INC, 4'h4, 16'h0800, 16'h0, F_W);
    cr(16'h0800, 1'b1, 16'h0810);
    check("bitrev_hit", rsp.bitrev_hit, 1'b1);
    rq(AM_POST_INC, 4'h4, 16'h0810, 16'h0, F_W);
    cr(16'h0810, 1'b1, 16'h0808);
    rq(AM_PRE_INC, 4'h4, 16'h0808, 16'h0, F_W);
    cr(16'h0818, 1'b1, 16'h0818);
    rq(AM_POST_INC, 4'h4, 16'h0800, 16'h0, F_W | F_B);
    cr(16'h0800, 1'b1, 16'h0801);
    rq(AM_POST_INC, 4'h4, 16'h080E, 16'h0, 5'h0);
    cr(16'h080E, 1'b1, 16'h0800);
    rq(AM_POST_DEC, 4'h4, 16'h0802, 16'h0, F_W);
    cr(16'h0802, 1'b1, 16'h0800);
  endtask

  task automatic t_prefetch;
    wb(1'b1, OFS_ADDR_MODE_CONTROL, 16'h0FFF);
    for (int k = 0; k < 8; k++)
    begin
      rq(pf_mode[k], pf_idx[k], 16'h0100, 16'h0, F_P);
      check("pf_err", rsp.mode_err, 1'(k > 4));
      check("pf_wb", rsp.wb_en, 1'(k < 3));
      if (k < 5)
        check("pf_y", rsp.y_space, 1'(pf_idx[k] > 4'h9));
      if (k < 3)
        check("pf_val", rsp.wb_val, 16'h0102 + 16'(2 * k));
    end
    rq(AM_PRE_INC, 4'h8, 16'h0100, 16'h0, F_P);
    check("pf_pre_err", rsp.mode_err, 1'b1);
    check("pf_pre_wb", rsp.wb_en, 1'b0);
    wb(1'b0, OFS_AGU_STATUS, 16'h0);
    check("status_err", q[STAT_ERR_BIT], 1'b1);
  endtask

  task automatic t_lit_move;
    for (int k = 0; k < 4; k++)
    begin
      rq(lit_mode[k], 4'h0, 16'h0, 16'hC5AB, 5'h0);
      check("lit", rsp.lit, lit_exp[k]);
    end
    rq(AM_REG_OFS, 4'h1, 16'h0200, 16'h0006, 5'h0);
    cr(16'h0206, 1'b0, 16'h0);
    rq(AM_REG_OFS, 4'h2, 16'h0300, 16'h0000, F_D | F_W);
    cr(16'h0306, 1'b0, 16'h0);
  endtask

  // ==========================================================================
  // Verdict and run control
  task automatic results;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (4000) @(posedge clk_i);
    num_errors++;
    results();
  end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_xcirc();
    t_ycirc();
    t_bitrev();
    t_prefetch();
    t_lit_move();
    results();
  end
endmodule
`default_nettype wire
